//--- src/rdxc_top.v
// Descriptor transfer unit: fetch, move, update and write back per activation
`timescale 1ns/100ps
`default_nettype none
`include "rdxc_defines.vh"

module rdxc_top (
  input  wire        clock,
  input  wire        reset_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  output reg         irq,
  // Activation from interrupt sources
  input  wire        act_req,
  input  wire [6:0]  act_chan,
  output reg         act_ack,
  input  wire        onchip_ram_enable,
  // Interrupt forwarded to the CPU
  output reg         cpu_irq_fwd,
  output reg  [6:0]  cpu_irq_chan,
  // Internal system bus
  output wire        mem_req,
  output wire        mem_we,
  output wire [23:0] mem_addr,
  output wire [31:0] mem_wdata,
  output wire [1:0]  mem_size,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_RD0  = 4'h1;
  localparam [3:0] S_RD1  = 4'h2;
  localparam [3:0] S_RD2  = 4'h3;
  localparam [3:0] S_XRD  = 4'h4;
  localparam [3:0] S_XWR  = 4'h5;
  localparam [3:0] S_WB0  = 4'h6;
  localparam [3:0] S_WB1  = 4'h7;
  localparam [3:0] S_WB2  = 4'h8;
  localparam [3:0] S_FIN  = 4'h9;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg         pend_r;
  reg  [6:0]  chan_r;
  reg  [23:0] desc_r;
  reg  [7:0]  mode_a_r;
  reg  [7:0]  mode_b_r;
  reg  [23:0] src_r;
  reg  [23:0] dst_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_rsv_r;
  reg  [31:0] data_r;
  reg  [1:0]  ctrl_r;
  reg  [2:0]  status_r;
  reg  [2:0]  status_nxt;
  reg  [2:0]  irq_en_r;
  reg  [23:0] last_src_r;
  reg  [23:0] last_dst_r;
  reg  [15:0] xfer_cnt_r;

  reg         bp_start;
  reg         bp_we;
  reg  [23:0] bp_addr;
  reg  [31:0] bp_wdata;
  wire        bp_busy;
  wire        bp_done;
  wire [31:0] bp_rdata;

  reg  [2:0]  ev;
  reg  [2:0]  clr;
  reg  [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded mode fields
  wire [1:0]  src_mode = mode_a_r[`RDXC_MA_SRC_POS+1:`RDXC_MA_SRC_POS];
  wire [1:0]  dst_mode = mode_a_r[`RDXC_MA_DST_POS+1:`RDXC_MA_DST_POS];
  wire [1:0]  unit_sz  = mode_a_r[`RDXC_MA_SIZE_POS+1:`RDXC_MA_SIZE_POS];
  wire        per_transfer_irq_select = mode_b_r[`RDXC_MB_IRQSEL_POS];

  wire [23:0] step = (unit_sz == `RDXC_SZ_BYTE) ? 24'h000001 :
                     (unit_sz == `RDXC_SZ_WORD) ? 24'h000002 : 24'h000004;

  wire [23:0] src_next = (src_mode == `RDXC_AM_INC) ? src_r + step :
                         (src_mode == `RDXC_AM_DEC) ? src_r - step : src_r;
  wire [23:0] dst_next = (dst_mode == `RDXC_AM_INC) ? dst_r + step :
                         (dst_mode == `RDXC_AM_DEC) ? dst_r - step : dst_r;
  wire [15:0] cnt_next = cnt_r - 16'h0001;
  wire        cnt_zero = (cnt_next == 16'h0000);

  // Window base and per-channel offset; 84 * 12 stays inside 10 bits
  wire [23:0] win_base = ctrl_r[`RDXC_CTRL_ALT_POS] ? `RDXC_WIN_BASE_ALT :
                                                     `RDXC_WIN_BASE_MAIN;
  wire [9:0]  chan_ofs = {3'h0, act_chan} * `RDXC_DESC_BYTES;
  wire [23:0] desc_addr = win_base | {14'h0000, chan_ofs};

  wire        chan_ok = (act_chan < `RDXC_MAX_CHAN);
  wire        in_access = (state_r != S_IDLE) && (state_r != S_FIN);
  wire        take = (state_r == S_IDLE) && act_req && !act_ack &&
                     ctrl_r[`RDXC_CTRL_EN_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Bus access issue per state
  always @* begin
    bp_start = in_access && !pend_r && !bp_busy;
    bp_we    = 1'b0;
    bp_addr  = desc_r;
    bp_wdata = 32'h00000000;
    case (state_r)
      S_RD0: begin
        bp_addr = desc_r + `RDXC_W0_OFS;
      end
      S_RD1: begin
        bp_addr = desc_r + `RDXC_W1_OFS;
      end
      S_RD2: begin
        bp_addr = desc_r + `RDXC_W2_OFS;
      end
      S_XRD: begin
        bp_addr = src_r;
      end
      S_XWR: begin
        bp_we    = 1'b1;
        bp_addr  = dst_r;
        bp_wdata = data_r;
      end
      S_WB0: begin
        bp_we    = 1'b1;
        bp_addr  = desc_r + `RDXC_W0_OFS;
        bp_wdata = {mode_a_r, src_r};
      end
      S_WB1: begin
        bp_we    = 1'b1;
        bp_addr  = desc_r + `RDXC_W1_OFS;
        bp_wdata = {mode_b_r, dst_r};
      end
      S_WB2: begin
        bp_we    = 1'b1;
        bp_addr  = desc_r + `RDXC_W2_OFS;
        bp_wdata = {cnt_r, cnt_rsv_r};
      end
      default: begin
        bp_start = 1'b0;
      end
    endcase
  end

  // Sizes of descriptor traffic are always longword; data uses the mode size
  wire [1:0] bp_size = ((state_r == S_XRD) || (state_r == S_XWR)) ? unit_sz :
                                                                   `RDXC_SZ_LONG;

  rdxc_bus_port u_bus (
    .clock       (clock),
    .reset_n     (reset_n),
    .start       (bp_start),
    .start_we    (bp_we),
    .start_addr  (bp_addr),
    .start_wdata (bp_wdata),
    .start_size  (bp_size),
    .busy        (bp_busy),
    .done        (bp_done),
    .rdata       (bp_rdata),
    .mem_req     (mem_req),
    .mem_we      (mem_we),
    .mem_addr    (mem_addr),
    .mem_wdata   (mem_wdata),
    .mem_size    (mem_size),
    .mem_ack     (mem_ack),
    .mem_rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence: no new activation until write-back has finished
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (take && onchip_ram_enable && chan_ok) begin
          state_nxt = S_RD0;
        end
      end
      S_RD0: begin
        if (bp_done) state_nxt = S_RD1;
      end
      S_RD1: begin
        if (bp_done) state_nxt = S_RD2;
      end
      S_RD2: begin
        if (bp_done) state_nxt = S_XRD;
      end
      S_XRD: begin
        if (bp_done) state_nxt = S_XWR;
      end
      S_XWR: begin
        if (bp_done) state_nxt = S_WB0;
      end
      S_WB0: begin
        if (bp_done) state_nxt = S_WB1;
      end
      S_WB1: begin
        if (bp_done) state_nxt = S_WB2;
      end
      S_WB2: begin
        if (bp_done) state_nxt = S_FIN;
      end
      S_FIN: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      pend_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (bp_done) begin
        pend_r <= 1'b0;
      end else if (bp_start) begin
        pend_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor image: whatever RAM holds at activation is used as is
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chan_r    <= 7'h00;
      desc_r    <= 24'h000000;
      mode_a_r  <= 8'h00;
      mode_b_r  <= 8'h00;
      src_r     <= 24'h000000;
      dst_r     <= 24'h000000;
      cnt_r     <= 16'h0000;
      cnt_rsv_r <= 16'h0000;
      data_r    <= 32'h00000000;
    end else begin
      if (take) begin
        chan_r <= act_chan;
        desc_r <= desc_addr;
      end
      if (bp_done) begin
        case (state_r)
          S_RD0: begin
            mode_a_r <= bp_rdata[31:`RDXC_MODE_POS];
            src_r    <= bp_rdata[`RDXC_ADDR_MSB:0];
          end
          S_RD1: begin
            mode_b_r <= bp_rdata[31:`RDXC_MODE_POS];
            dst_r    <= bp_rdata[`RDXC_ADDR_MSB:0];
          end
          S_RD2: begin
            cnt_r     <= bp_rdata[31:`RDXC_CNT_POS];
            cnt_rsv_r <= bp_rdata[`RDXC_CNT_POS-1:0];
          end
          S_XRD: begin
            data_r <= bp_rdata;
          end
          S_XWR: begin
            src_r <= src_next;
            dst_r <= dst_next;
            cnt_r <= cnt_next;
          end
          default: begin
            data_r <= data_r;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding to the CPU and activation acknowledge
  reg fin_zero_r;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      act_ack      <= 1'b0;
      cpu_irq_fwd  <= 1'b0;
      cpu_irq_chan <= 7'h00;
      fin_zero_r   <= 1'b0;
      last_src_r   <= 24'h000000;
      last_dst_r   <= 24'h000000;
      xfer_cnt_r   <= 16'h0000;
    end else begin
      act_ack     <= take;
      cpu_irq_fwd <= 1'b0;
      if ((state_r == S_XWR) && bp_done) begin
        fin_zero_r <= cnt_zero;
      end
      // Refused activation goes straight on to the CPU
      if (take && !(onchip_ram_enable && chan_ok)) begin
        cpu_irq_fwd  <= 1'b1;
        cpu_irq_chan <= act_chan;
      end
      if (state_r == S_FIN) begin
        last_src_r <= src_r;
        last_dst_r <= dst_r;
        xfer_cnt_r <= xfer_cnt_r + 16'h0001;
        if (per_transfer_irq_select || fin_zero_r) begin
          cpu_irq_fwd  <= 1'b1;
          cpu_irq_chan <= chan_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status events; a set in the clearing cycle survives
  always @* begin
    ev = 3'h0;
    ev[`RDXC_ST_XFER_POS] = (state_r == S_FIN);
    ev[`RDXC_ST_DONE_POS] = (state_r == S_FIN) && fin_zero_r;
    ev[`RDXC_ST_ERR_POS]  = take && !(onchip_ram_enable && chan_ok);
    clr = 3'h0;
    if (reg_write && (reg_addr == `RDXC_REG_IRQ_CLR)) begin
      clr = reg_wdata[`RDXC_ST_BITS-1:0];
    end
    status_nxt = (status_r & ~clr) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `RDXC_REG_CTRL:     rd_mux = {30'h00000000, ctrl_r};
      `RDXC_REG_STATUS:   rd_mux = {29'h00000000, status_r};
      `RDXC_REG_IRQ_EN:   rd_mux = {29'h00000000, irq_en_r};
      `RDXC_REG_STATE:    rd_mux = {20'h00000, chan_r, 1'b0, state_r};
      `RDXC_REG_LAST_SRC: rd_mux = {8'h00, last_src_r};
      `RDXC_REG_LAST_DST: rd_mux = {8'h00, last_dst_r};
      `RDXC_REG_XFER_CNT: rd_mux = {16'h0000, xfer_cnt_r};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r    <= `RDXC_CTRL_RST;
      status_r  <= `RDXC_ST_RST;
      irq_en_r  <= `RDXC_ST_RST;
      reg_rdata <= 32'h00000000;
      irq       <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & irq_en_r);
      if (reg_write && (reg_addr == `RDXC_REG_CTRL)) begin
        ctrl_r <= reg_wdata[1:0];
      end
      if (reg_write && (reg_addr == `RDXC_REG_IRQ_EN)) begin
        irq_en_r <= reg_wdata[`RDXC_ST_BITS-1:0];
      end
      // Data valid only in the cycle after the read strobe
      if (reg_read) begin
        reg_rdata <= rd_mux;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

//--- src/rdxc_defines.vh
// Constants shared by the descriptor transfer unit and its bus port
`ifndef RDXC_DEFINES_VH
`define RDXC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Descriptor window and layout
`define RDXC_WIN_BASE_MAIN   24'hfff800
`define RDXC_WIN_BASE_ALT    24'hffec00
`define RDXC_DESC_BYTES      10'h00c
`define RDXC_MAX_CHAN        7'h55
`define RDXC_W0_OFS          24'h000000
`define RDXC_W1_OFS          24'h000004
`define RDXC_W2_OFS          24'h000008
`define RDXC_MODE_POS        24
`define RDXC_ADDR_MSB        23
`define RDXC_CNT_POS         16

////////////////////////////////////////////////////////////////////////////////
// Mode register A: address step modes and unit size
`define RDXC_MA_SRC_POS      6
`define RDXC_MA_DST_POS      4
`define RDXC_MA_SIZE_POS     0
`define RDXC_AM_FIXED        2'h0
`define RDXC_AM_INC          2'h2
`define RDXC_AM_DEC          2'h3
`define RDXC_SZ_BYTE         2'h0
`define RDXC_SZ_WORD         2'h1
`define RDXC_SZ_LONG         2'h2

// Mode register B: per-transfer interrupt select
`define RDXC_MB_IRQSEL_POS   3

////////////////////////////////////////////////////////////////////////////////
// Register port map
`define RDXC_REG_CTRL        8'h00
`define RDXC_REG_STATUS      8'h04
`define RDXC_REG_IRQ_EN      8'h08
`define RDXC_REG_IRQ_CLR     8'h0c
`define RDXC_REG_STATE       8'h10
`define RDXC_REG_LAST_SRC    8'h14
`define RDXC_REG_LAST_DST    8'h18
`define RDXC_REG_XFER_CNT    8'h1c

`define RDXC_CTRL_EN_POS     0
`define RDXC_CTRL_ALT_POS    1
`define RDXC_CTRL_RST        2'h0

`define RDXC_ST_XFER_POS     0
`define RDXC_ST_DONE_POS     1
`define RDXC_ST_ERR_POS      2
`define RDXC_ST_BITS         3
`define RDXC_ST_RST          3'h0

`endif

//--- src/rdxc_bus_port.v
// Single-access master on the internal system bus
`timescale 1ns/100ps
`default_nettype none
`include "rdxc_defines.vh"

module rdxc_bus_port (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        start,
  input  wire        start_we,
  input  wire [23:0] start_addr,
  input  wire [31:0] start_wdata,
  input  wire [1:0]  start_size,
  output reg         busy,
  output reg         done,
  output reg  [31:0] rdata,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [23:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [1:0]  mem_size,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);

  // Request held until acknowledged; one access in flight only
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 32'h00000000;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 24'h000000;
      mem_wdata <= 32'h00000000;
      mem_size  <= 2'h0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy      <= 1'b1;
          mem_req   <= 1'b1;
          mem_we    <= start_we;
          mem_addr  <= start_addr;
          mem_wdata <= start_wdata;
          mem_size  <= start_size;
        end
      end else if (mem_ack) begin
        busy    <= 1'b0;
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
        done    <= 1'b1;
        if (!mem_we) begin
          rdata <= mem_rdata;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- bench/rdxc_chk_sva.sv
// Port assertions for the descriptor transfer unit
`timescale 1ns/100ps
`default_nettype none
module rdxc_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        act_req,
  input wire logic        act_ack,
  input wire logic        cpu_irq_fwd,
  input wire logic [6:0]  cpu_irq_chan,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0]  mem_size,
  input wire logic        mem_ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire in_win = mem_addr[23:10] == 14'h3ffe || mem_addr[23:10] == 14'h3ffb;
  property p_ack_once; act_ack |=> !act_ack; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("act_ack longer than one cycle");
  property p_ack_idle; act_ack |-> $past(act_req) && !mem_req; endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("activation taken while busy");
  property p_fetch;
    act_ack && !cpu_irq_fwd |=> mem_req && !mem_we && in_win && mem_size == 2'h2;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("first fetch not a window long read");
  property p_refuse; act_ack && cpu_irq_fwd |-> ##1 !mem_req [*4]; endproperty
  a_refuse: assert property (p_refuse)
    else $error("bus traffic on refused activation");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata) &&
      $stable(mem_we) && $stable(mem_size);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus request changed before ack");
  property p_limit; mem_req && in_win |-> mem_addr[9:0] < 10'h3fc && mem_addr[1:0] == 2'h0;
  endproperty
  a_limit: assert property (p_limit)
    else $error("descriptor access past last slot");
  property p_fwd_once; cpu_irq_fwd |=> !cpu_irq_fwd; endproperty
  a_fwd_once: assert property (p_fwd_once)
    else $error("forward longer than one cycle");
  property p_chan; $changed(cpu_irq_chan) |-> cpu_irq_fwd; endproperty
  a_chan: assert property (p_chan)
    else $error("forward channel moved without forward");
  property p_fwd_idle; cpu_irq_fwd |-> !mem_req; endproperty
  a_fwd_idle: assert property (p_fwd_idle)
    else $error("forward before write-back");
  c_refuse: cover property (act_ack && cpu_irq_fwd);
  c_stall: cover property ((mem_req && !mem_ack) [*3]);
  c_fwd: cover property (cpu_irq_fwd && !act_ack);
endmodule
bind rdxc_top rdxc_chk u_chk (.clock(clock), .reset_n(reset_n), .act_req(act_req),
  .act_ack(act_ack), .cpu_irq_fwd(cpu_irq_fwd), .cpu_irq_chan(cpu_irq_chan),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_size(mem_size), .mem_ack(mem_ack));
`default_nettype wire

//--- bench/rdxc_mem_model.sv
// Internal bus slave with byte RAM and selectable wait states
`timescale 1ns/100ps
`default_nettype none
module rdxc_mem_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [1:0]  wait_cycles,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  // Low 16 address bits only; bench keeps its regions apart
  logic [7:0] ram [0:65535];
  logic [1:0] wait_r;
  function automatic int nbytes(input logic [1:0] sz);
    return (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
  endfunction
  function automatic logic [31:0] peek(input logic [15:0] a, input logic [1:0] sz);
    logic [31:0] v;
    v = {ram[a], ram[a + 16'h1], ram[a + 16'h2], ram[a + 16'h3]};
    return v >> (8 * (4 - nbytes(sz)));
  endfunction
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      // Stale read data keeps toggling so it never passes for valid
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack) begin
        if (mem_we) begin
          for (int i = 0; i < nbytes(mem_size); i++)
            ram[mem_addr[15:0] + 16'(i)] <= mem_wdata[8 * (nbytes(mem_size) - 1 - i) +: 8];
        end
      end else if (mem_req) begin
        if (wait_r == wait_cycles) begin
          mem_ack <= 1'b1;
          wait_r <= 2'h0;
          if (!mem_we)
            mem_rdata <= peek(mem_addr[15:0], mem_size);
        end else
          wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the descriptor transfer unit
`timescale 1ns/100ps
`default_nettype none
`include "rdxc_defines.vh"
module testbench;
  logic        clock, reset_n, reg_write, reg_read, irq, act_req, act_ack;
  logic        onchip_ram_enable, cpu_irq_fwd, mem_req, mem_we, mem_ack;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, rnd, v;
  logic [6:0]  act_chan, cpu_irq_chan, fwd_ch;
  logic [23:0] mem_addr;
  logic [1:0]  mem_size, wait_cycles;
  int          num_errors, checked, fwd_cnt, wr_cnt, xfers;
  rdxc_top u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .act_req(act_req), .act_chan(act_chan),
    .act_ack(act_ack), .onchip_ram_enable(onchip_ram_enable), .cpu_irq_fwd(cpu_irq_fwd),
    .cpu_irq_chan(cpu_irq_chan), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  rdxc_mem_model u_mem (.clock(clock), .reset_n(reset_n), .wait_cycles(wait_cycles),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (reset_n && cpu_irq_fwd) begin
      fwd_cnt++;
      fwd_ch = cpu_irq_chan;
    end
    if (reset_n && mem_req && mem_ack && mem_we)
      wr_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rand32();
    rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h00400007 : 32'h0);
    return rnd;
  endfunction
  function automatic logic [23:0] step(input logic [1:0] md, input logic [1:0] sz);
    logic [23:0] n;
    n = (sz == 2'h0) ? 24'h1 : (sz == 2'h1) ? 24'h2 : 24'h4;
    return (md == `RDXC_AM_INC) ? n : (md == `RDXC_AM_DEC) ? -n : 24'h0;
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task put32(input logic [23:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      u_mem.ram[a[15:0] + 16'(i)] = d[8 * (3 - i) +: 8];
  endtask
  task activate(input logic [6:0] ch);
    @(posedge clock);
    act_req <= 1'b1;
    act_chan <= ch;
    for (int n = 0; n < 200 && act_ack !== 1'b1; n++)
      @(posedge clock) #1;
    check("act_ack", act_ack, 1'b1);
    @(posedge clock);
    act_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [6:0] ch, input logic alt);
    logic [23:0] d, src, dst;
    logic [31:0] r, data;
    logic [15:0] cnt;
    logic [7:0]  ma;
    logic        sel, fwd;
    int          w0, f0;
    r = rand32();
    data = rand32();
    d = (alt ? `RDXC_WIN_BASE_ALT : `RDXC_WIN_BASE_MAIN) | (24'(ch) * 24'h00c);
    ma = {r[7:4], 2'h0, 2'(r[9:8] % 3)};
    sel = r[10];
    cnt = 16'(r[12:11]);
    fwd = sel || cnt == 16'h1;
    src = {12'h001, r[20:13], 4'h0};
    dst = {12'h004, r[28:21], 4'h0};
    put32(d + 24'h8, {cnt, r[31:16]});
    put32(d, {8'h00, src});
    put32(d + 24'h4, {8'h00, dst});
    u_mem.ram[d[15:0]] = ma;
    u_mem.ram[d[15:0] + 16'h4] = {4'h0, sel, 3'h0};
    put32(src, data);
    w0 = wr_cnt;
    f0 = fwd_cnt;
    xfers++;
    activate(ch);
    for (int n = 0; n < 400 && wr_cnt != w0 + 4; n++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    check("dst data", u_mem.peek(dst[15:0], ma[1:0]),
          (ma[1:0] == 2'h0) ? {24'h0, data[31:24]} :
          (ma[1:0] == 2'h1) ? {16'h0, data[31:16]} : data);
    check("word0", u_mem.peek(d[15:0], 2'h2), {ma, src + step(ma[7:6], ma[1:0])});
    check("word1", u_mem.peek(d[15:0] + 16'h4, 2'h2),
          {4'h0, sel, 3'h0, dst + step(ma[5:4], ma[1:0])});
    check("word2", u_mem.peek(d[15:0] + 16'h8, 2'h2), {cnt - 16'h1, r[31:16]});
    check("forwards", fwd_cnt - f0, {31'h0, fwd});
    if (fwd) begin
      check("fwd chan", fwd_ch, ch);
    end
    reg_rd(`RDXC_REG_STATUS, v);
    check("status", v, {30'h0, cnt == 16'h1, 1'b1});
    check("irq set", irq, 1'b1);
    reg_wr(`RDXC_REG_IRQ_CLR, 32'h7);
    reg_rd(`RDXC_REG_LAST_SRC, v);
    check("last src", v, {8'h0, src + step(ma[7:6], ma[1:0])});
    reg_rd(`RDXC_REG_LAST_DST, v);
    check("last dst", v, {8'h0, dst + step(ma[5:4], ma[1:0])});
    reg_rd(`RDXC_REG_XFER_CNT, v);
    check("xfer count", v, {16'h0, 16'(xfers)});
    reg_rd(`RDXC_REG_STATE, v);
    check("state idle", v, {20'h0, ch, 1'b0, 4'h0});
    check("irq clear", irq, 1'b0);
  endtask
  task refuse(input logic [6:0] ch, input logic exp_irq);
    int f0;
    f0 = fwd_cnt;
    activate(ch);
    repeat (3) @(posedge clock);
    check("refused fwd", fwd_cnt - f0, 1);
    reg_rd(`RDXC_REG_STATUS, v);
    check("refused flag", v, 32'h4);
    check("refused irq", irq, exp_irq);
    reg_wr(`RDXC_REG_IRQ_CLR, 32'h7);
  endtask
  task results;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_write, reg_read, act_req, onchip_ram_enable} = 5'h0;
    {reg_addr, reg_wdata, act_chan, wait_cycles} = 49'h0;
    {num_errors, checked, fwd_cnt, wr_cnt} = 128'h0;
    rnd = 32'h0bfd;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    // Every mapped register plus one unmapped slot reads zero after reset
    for (int i = 0; i < 9; i++) begin
      reg_rd(8'(4 * i), v);
      check("reset read", v, 32'h0);
    end
    onchip_ram_enable <= 1'b1;
    reg_wr(`RDXC_REG_IRQ_EN, 32'h7);
    for (int i = 0; i < 24; i++) begin
      wait_cycles <= 2'(rand32() % 4);
      reg_wr(`RDXC_REG_CTRL, {30'h0, i >= 18, 1'b1});
      xfer((i == 0) ? 7'h0 : (i % 6 == 1) ? 7'h54 : 7'(rand32() % 85), i >= 18);
    end
    refuse(7'h55, 1'b1);
    onchip_ram_enable <= 1'b0;
    refuse(7'h03, 1'b1);
    onchip_ram_enable <= 1'b1;
    reg_wr(`RDXC_REG_IRQ_EN, 32'h0);
    refuse(7'h7f, 1'b0);
    // Disabled unit must leave a standing request unanswered
    reg_wr(`RDXC_REG_CTRL, 32'h0);
    @(posedge clock);
    act_req <= 1'b1;
    act_chan <= 7'h01;
    repeat (8) @(posedge clock);
    #1 check("ignored ack", act_ack, 1'b0);
    @(posedge clock);
    act_req <= 1'b0;
    reg_rd(`RDXC_REG_STATUS, v);
    check("ignored status", v, 32'h0);
    results;
  end
endmodule
`default_nettype wire
